// >>> tb_user_row_config_loader.sv
// Self-checking bench for ucl_loader with a behavioural row.
// Assumes an AHB-Lite slave of any latency and a reload through CTRL.
`timescale 1ns/10ps

module tb_user_row_config_loader;
	logic hclk, hresetn, hsel, hwrite, hready, nvm_rvalid, rdp = 1'b0;
	logic hreadyout, hresp, nvm_rd, units_release, crc_mismatch;
	logic wdog_standby_run_fuse, wdog_enable_fuse, wdog_always_on_fuse;
	logic wdog_window_enable_fuse, brownout_hysteresis_fuse;
	logic ram_no_execute, dataflash_no_execute, user_row_write_allow;
	logic [1:0] htrans;
	logic [2:0] hsize, nvm_addr, lat;
	logic [3:0] wdog_period_fuse, wdog_window_timeout_fuse;
	logic [3:0] wdog_early_warning_fuse, dataflash_secure_size;
	logic [5:0] app_callable_size;
	logic [6:0] ram_secure_size;
	logic [7:0] app_secure_size;
	logic [10:0] app_callable_bytes;
	logic [11:0] dataflash_secure_bytes;
	logic [13:0] ram_secure_bytes;
	logic [15:0] app_secure_bytes;
	logic [31:0] haddr, hwdata, hrdata, nvm_rdata;
	logic [31:0] bridge_a_nonsecure_word, bridge_b_nonsecure_word;
	logic [31:0] bridge_c_nonsecure_word;
	logic [255:0] row;
	logic bad;
	logic [31:0] rq[$];
	logic [194:0] tq[$];
	int n_mismatch = 0, compares = 0;
	event chk_ev;
	wire logic [194:0] act = {wdog_standby_run_fuse, wdog_enable_fuse,
		wdog_always_on_fuse, wdog_period_fuse, wdog_window_timeout_fuse,
		wdog_early_warning_fuse, wdog_window_enable_fuse,
		brownout_hysteresis_fuse, ram_no_execute, dataflash_no_execute,
		app_secure_size, app_callable_size, dataflash_secure_size,
		ram_secure_size, app_secure_bytes, app_callable_bytes,
		dataflash_secure_bytes, ram_secure_bytes, user_row_write_allow,
		bridge_a_nonsecure_word, bridge_b_nonsecure_word,
		bridge_c_nonsecure_word, crc_mismatch};

	assign hready = hreadyout;
	ucl_loader u_ucl_loader (.*);
	ucl_row_model u_ucl_row_model (.*);

	// Reference checksum, msb first, words 2 to 6
	function automatic logic [31:0] crc(input logic [255:0] r);
		logic [31:0] c;
		c = ucl_pkg::CRC_INIT;
		for (int w = 2; w <= 6; w++)
			for (int b = 31; b >= 0; b--)
				c = {c[30:0], 1'b0} ^
					((c[31] ^ r[32*w+b]) ? ucl_pkg::CRC_POLY : 32'h0);
		return c;
	endfunction

	// Expected targets; reserved bits of the row never reach them
	function automatic logic [194:0] exp_t(input logic [255:0] r);
		return {r[25], r[26], r[27], r[31:28], r[35:32], r[39:36], r[40],
			r[41], r[43], r[44], r[71:64], r[77:72], r[83:80], r[94:88],
			r[71:64], 8'h00, r[77:72], 5'h00, r[83:80], 8'h00, r[94:88],
			7'h00, r[96], r[159:129], 1'b0, r[191:163], 3'b100,
			r[223:192], bad};
	endfunction

	task automatic cmp32(input string n, input logic [31:0] e, a);
		compares++;
		if (a !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", n, e, a);
		end
	endtask

	task automatic cmpt(input logic [194:0] e, a);
		compares++;
		if (a !== e)
		begin
			n_mismatch++;
			$display("MISMATCH targets exp %h got %h", e, a);
		end
	endtask

	task automatic bus(input logic w, input logic [31:0] a, d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	task automatic rd(input logic [31:0] a, e);
		rq.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask

	// Random row, fixed core calibration byte, good or broken checksum
	task automatic mk_row(input int i);
		for (int w = 0; w < 8; w++)
			row[32*w +: 32] = $urandom;
		row[23:16] = 8'h5A;
		bad = i[0] && i != 3; // Checking is switched off for the last row
		row[255:224] = crc(row) ^ {31'h0, i[0]};
		lat = 3'(i + 1);
	endtask

	task automatic tally_and_finish;
		if (n_mismatch == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// Watchdog well beyond four loads and their reads
	initial
	begin
		#50000;
		n_mismatch++;
		tally_and_finish();
	end

	// Read data taken at the data-phase edge
	always @(posedge hclk)
	begin
		if (rdp && hreadyout === 1'b1)
			cmp32("hrdata", rq.pop_front(), hrdata);
		rdp <= hsel && htrans[1] && !hwrite && hreadyout;
	end

	// Targets judged once settled after release
	always @(posedge units_release or chk_ev)
	begin
		#1;
		cmpt(tq.pop_front(), act);
	end

	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		void'($urandom(32'hda6b7575));
		mk_row(0);
		repeat (2) @(posedge hclk);
		tq.push_back({3'h0, 12'hBBB, 4'h3, 8'hFF, 6'h00, 4'h8, 7'h7F,
			16'hFF00, 11'h000, 12'h800, 14'h3F80, 1'b1, 97'h0});
		->chk_ev;
		hresetn <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			if (i > 0)
			begin
				mk_row(i);
				bus(1'b1, 32'(ucl_pkg::REG_CTRL), {30'h0, i != 3, 1'b1});
				rd(32'(ucl_pkg::REG_STATUS), 32'h4);
			end
			tq.push_back(exp_t(row));
			for (int k = 0; k < 400 && units_release !== 1'b1; k++)
				@(posedge hclk);
			cmp32("units_release", 32'h1, 32'(units_release));
			rd(32'(ucl_pkg::REG_CTRL), {30'h0, i != 3, 1'b0});
			rd(32'(ucl_pkg::REG_STATUS), {30'h0, bad, 1'b1});
			rd(32'(ucl_pkg::REG_CRC_CALC), crc(row));
			rd(32'(ucl_pkg::REG_CRC_STORED), row[255:224]);
			rd(32'h10, 32'h0);
			bus(1'b1, 32'(ucl_pkg::REG_STATUS), 32'h2);
			rd(32'(ucl_pkg::REG_STATUS), 32'h1);
		end
		repeat (2) @(posedge hclk);
		cmp32("notes", 32'h0, 32'(tq.size() + rq.size()));
		tally_and_finish();
	end
endmodule

// >>> ucl_assertions.sv
// Port-level checks of the user-row loader.
// Single hclk domain; bound to every ucl_loader instance.
`timescale 1ns/10ps

module ucl_assertions
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        nvm_rd,
	input wire logic        units_release,
	input wire logic [3:0]  wdog_period_fuse,
	input wire logic [7:0]  app_secure_size,
	input wire logic [5:0]  app_callable_size,
	input wire logic [3:0]  dataflash_secure_size,
	input wire logic [6:0]  ram_secure_size,
	input wire logic [15:0] app_secure_bytes,
	input wire logic [10:0] app_callable_bytes,
	input wire logic [11:0] dataflash_secure_bytes,
	input wire logic [13:0] ram_secure_bytes,
	input wire logic [31:0] bridge_a_nonsecure_word,
	input wire logic [31:0] bridge_b_nonsecure_word,
	input wire logic [31:0] bridge_c_nonsecure_word
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Read strobe is a single-cycle pulse
	sequence rd_pulse;
		nvm_rd ##1 !nvm_rd;
	endsequence
	// Two released cycles in a row
	sequence settled;
		units_release ##1 units_release;
	endsequence

	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	rd_single_a: assert property (nvm_rd |-> rd_pulse)
		else $error("row read strobe longer than one cycle");
	release_quiet_a: assert property (units_release |-> !nvm_rd)
		else $error("row read while dependents released");
	targets_hold_a: assert property (settled |->
		$stable(bridge_c_nonsecure_word) && $stable(app_secure_size)
		&& $stable(wdog_period_fuse))
		else $error("target changed while released");
	app_bytes_a: assert property (
		app_secure_bytes == {app_secure_size, 8'h00})
		else $error("app secure bytes wrong");
	nsc_bytes_a: assert property (
		app_callable_bytes == {app_callable_size, 5'h00})
		else $error("callable bytes wrong");
	df_bytes_a: assert property (
		dataflash_secure_bytes == {dataflash_secure_size, 8'h00})
		else $error("data flash secure bytes wrong");
	ram_bytes_a: assert property (
		ram_secure_bytes == {ram_secure_size, 7'h00})
		else $error("ram secure bytes wrong");
	acc_secure_a: assert property (!bridge_a_nonsecure_word[0])
		else $error("access controller not secure");
	attr_secure_a: assert property (bridge_b_nonsecure_word[1:0] == 2'h0)
		else $error("attribution or memory ctrl not secure");
	dbg_open_a: assert property (
		units_release |-> bridge_b_nonsecure_word[2])
		else $error("debug unit not non-secure");
endmodule

bind ucl_loader ucl_assertions u_ucl_assertions (.*);

// >>> ucl_loader.sv
// User-row configuration loader with an AHB-Lite status slave.
// Assumes the row memory answers on hclk with a one-cycle rvalid pulse,
// and that dependent units stay in reset until units_release is high.
// Functional notes
// - Fuse bits 25,26,27 load watchdog standby-run, enable, always-on.
// - Bits 31:28 give watchdog period, 35:32 window timeout, default 0xB.
// - Bits 39:36 give the watchdog early-warning offset.
// - Bit 40 gives watchdog window-mode enable, default zero.
// - Bit 41 gives the supply brown-out hysteresis.
// - Bit 43 gives RAM execute-never, default one.
// - Bit 44 gives data-flash execute-never, default one.
// - Bits 71:64 give application secure size, times 0x100, default 0xFF.
// - Bits 77:72 give non-secure-callable size, times 0x20.
// - Bits 83:80 give secure data-flash size, times 0x100.
// - Bits 94:88 give secure RAM size, times 0x80, default 0x7F.
// - Bit 96 gives user-row write allow, default one.
// - Bits 159:128, 191:160, 223:192 give three bridge non-secure words.
// - Access controller stays secure whatever its bridge A bit.
// - Attribution unit and memory controller stay secure in bridge B.
// - Debug service unit is non-secure in bridge B from the first apply; reset leaves it secure.
// - Bits 255:224 hold a CRC over bits 223:64.
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps

module ucl_loader
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output logic             nvm_rd,
	output logic [2:0]       nvm_addr,
	input  wire logic [31:0] nvm_rdata,
	input  wire logic        nvm_rvalid,
	output logic             wdog_standby_run_fuse,
	output logic             wdog_enable_fuse,
	output logic             wdog_always_on_fuse,
	output logic [3:0]       wdog_period_fuse,
	output logic [3:0]       wdog_window_timeout_fuse,
	output logic [3:0]       wdog_early_warning_fuse,
	output logic             wdog_window_enable_fuse,
	output logic             brownout_hysteresis_fuse,
	output logic             ram_no_execute,
	output logic             dataflash_no_execute,
	output logic [7:0]       app_secure_size,
	output logic [5:0]       app_callable_size,
	output logic [3:0]       dataflash_secure_size,
	output logic [6:0]       ram_secure_size,
	output logic [15:0]      app_secure_bytes,
	output logic [10:0]      app_callable_bytes,
	output logic [11:0]      dataflash_secure_bytes,
	output logic [13:0]      ram_secure_bytes,
	output logic             user_row_write_allow,
	output logic [31:0]      bridge_a_nonsecure_word,
	output logic [31:0]      bridge_b_nonsecure_word,
	output logic [31:0]      bridge_c_nonsecure_word,
	output logic             units_release,
	output logic             crc_mismatch
);

	ucl_pkg::ucl_state_e state_q;
	ucl_pkg::ucl_state_e state_d;
	logic [2:0]  idx_q;
	logic [31:0] crc_q;
	logic        check_en_q;
	logic        crc_err_q;
	logic        done_q;
	logic        rd_q;
	logic        hready_q;
	logic        hresp_q;
	logic [31:0] hrdata_q;
	logic        wr_pend_q;
	logic [31:0] wr_addr_q;
	logic [31:0] row_q [ucl_pkg::ROW_WORDS];
	wire logic [255:0] row_flat;

	// Word-aligned match of a bus address against a register offset
	function automatic logic reg_hit(logic [31:0] a, logic [7:0] off);
		reg_hit = (a[31:2] == {24'h00_0000, off[7:2]});
	endfunction

	// One 32-bit step of the row checksum, msb first
	function automatic logic [31:0] crc_step(logic [31:0] c,
		logic [31:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 31; i >= 0; i--)
		begin
			if (r[31] ^ d[i])
				r = {r[30:0], 1'b0} ^ ucl_pkg::CRC_POLY;
			else
				r = {r[30:0], 1'b0};
		end
		return r;
	endfunction

	// Bus decode
	wire logic bus_act = hsel & htrans[1] & hready;
	wire logic wr_ctrl = wr_pend_q & reg_hit(wr_addr_q, ucl_pkg::REG_CTRL);
	wire logic wr_stat = wr_pend_q & reg_hit(wr_addr_q, ucl_pkg::REG_STATUS);
	wire logic reload = wr_ctrl & hwdata[ucl_pkg::CTRL_RELOAD]
		& (state_q == ucl_pkg::S_DONE);
	wire logic crc_clr = wr_stat & hwdata[ucl_pkg::ST_CRC_ERR];

	// Loader handshakes
	wire logic got_word = (state_q == ucl_pkg::S_WAIT) & nvm_rvalid;
	wire logic last_word = (idx_q == ucl_pkg::CRC_STORE_WORD);
	wire logic in_crc = (idx_q >= ucl_pkg::CRC_FIRST_WORD)
		& (idx_q <= ucl_pkg::CRC_LAST_WORD);
	wire logic [31:0] stored_crc = row_flat[ucl_pkg::POS_CRC +: 32];
	wire logic crc_bad = check_en_q & (crc_q != stored_crc);
	wire logic crc_set = (state_q == ucl_pkg::S_CHECK) & crc_bad;
	wire logic apply = (state_q == ucl_pkg::S_APPLY);

	// Status read-back
	wire logic [31:0] status_word = {29'h0, state_q != ucl_pkg::S_DONE,
		crc_err_q, done_q};
	wire logic [31:0] ctrl_word = {30'h0, check_en_q, 1'b0};
	wire logic [31:0] rd_mux =
		reg_hit(haddr, ucl_pkg::REG_CTRL) ? ctrl_word :
		reg_hit(haddr, ucl_pkg::REG_STATUS) ? status_word :
		reg_hit(haddr, ucl_pkg::REG_CRC_CALC) ? crc_q :
		reg_hit(haddr, ucl_pkg::REG_CRC_STORED) ? stored_crc :
		32'h0000_0000;

	// Bridge words with the fixed attributes forced
	wire logic [31:0] bra_eff = row_flat[ucl_pkg::POS_BRIDGE_A +: 32]
		& ~ucl_pkg::BRA_SEC_MASK;
	wire logic [31:0] brb_eff = (row_flat[ucl_pkg::POS_BRIDGE_B +: 32]
		& ~ucl_pkg::BRB_SEC_MASK)
		| ucl_pkg::BRB_NS_MASK;
	wire logic [31:0] brc_eff = row_flat[ucl_pkg::POS_BRIDGE_C +: 32];

	// Region fields taken from the row
	wire logic [7:0] as_f = row_flat[ucl_pkg::POS_APP_SEC +: 8];
	wire logic [5:0] app_callable_size_f = row_flat[ucl_pkg::POS_APP_NSC +: 6];
	wire logic [3:0] ds_f = row_flat[ucl_pkg::POS_DF_SEC +: 4];
	wire logic [6:0] rs_f = row_flat[ucl_pkg::POS_RAM_SEC +: 7];

	// Row word capture, one register per word
	generate
		for (genvar g = 0; g < ucl_pkg::ROW_WORDS; g++)
		begin : g_word
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					row_q[g] <= 32'h0000_0000;
				else if (got_word && idx_q == 3'(g))
					row_q[g] <= nvm_rdata;
			end
			assign row_flat[g*32 +: 32] = row_q[g];
		end
	endgenerate

	// Sequencer: read every word, check, apply, then release
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ucl_pkg::S_REQ:   state_d = ucl_pkg::S_WAIT;
			ucl_pkg::S_WAIT:
				if (nvm_rvalid)
					state_d = last_word ? ucl_pkg::S_CHECK
						: ucl_pkg::S_REQ;
			ucl_pkg::S_CHECK: state_d = ucl_pkg::S_APPLY;
			ucl_pkg::S_APPLY: state_d = ucl_pkg::S_DONE;
			ucl_pkg::S_DONE:
				if (reload)
					state_d = ucl_pkg::S_REQ;
			default:          state_d = ucl_pkg::S_REQ;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state_q <= ucl_pkg::S_REQ;
		else
			state_q <= state_d;
	end

	// Word index and read strobe
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			idx_q <= 3'h0;
			rd_q <= 1'b0;
		end
		else
		begin
			rd_q <= (state_q == ucl_pkg::S_REQ);
			if (reload)
				idx_q <= 3'h0;
			else if (got_word && !last_word)
				idx_q <= idx_q + 3'h1;
		end
	end

	// Checksum accumulates only words 2..6
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			crc_q <= ucl_pkg::CRC_INIT;
		else if (reload)
			crc_q <= ucl_pkg::CRC_INIT;
		else if (got_word && in_crc)
			crc_q <= crc_step(crc_q, nvm_rdata);
	end

	// Sticky mismatch flag; a set beats a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			crc_err_q <= 1'b0;
		else if (crc_set)
			crc_err_q <= 1'b1;
		else if (crc_clr)
			crc_err_q <= 1'b0;
	end

	// Done and release rise at the very edge that writes the targets
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			done_q <= 1'b0;
		else if (reload)
			done_q <= 1'b0;
		else if (apply)
			done_q <= 1'b1;
	end

	// Watchdog and supply targets
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wdog_standby_run_fuse <= 1'b0;
			wdog_enable_fuse <= 1'b0;
			wdog_always_on_fuse <= 1'b0;
			wdog_period_fuse <= ucl_pkg::RST_WD_PER;
			wdog_window_timeout_fuse <= ucl_pkg::RST_WD_WIN;
			wdog_early_warning_fuse <= ucl_pkg::RST_WD_EW;
			wdog_window_enable_fuse <= 1'b0;
			brownout_hysteresis_fuse <= 1'b0;
		end
		else if (apply)
		begin
			wdog_standby_run_fuse <= row_flat[ucl_pkg::POS_WD_STBY];
			wdog_enable_fuse <= row_flat[ucl_pkg::POS_WD_EN];
			wdog_always_on_fuse <= row_flat[ucl_pkg::POS_WD_AON];
			wdog_period_fuse <= row_flat[ucl_pkg::POS_WD_PER +: 4];
			wdog_window_timeout_fuse <= row_flat[ucl_pkg::POS_WD_WIN +: 4];
			wdog_early_warning_fuse <= row_flat[ucl_pkg::POS_WD_EW +: 4];
			wdog_window_enable_fuse <= row_flat[ucl_pkg::POS_WD_WEN];
			brownout_hysteresis_fuse <= row_flat[ucl_pkg::POS_BOD_HYST];
		end
	end

	// Security targets; reserved row bits are never looked at
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ram_no_execute <= ucl_pkg::RST_RAM_NX;
			dataflash_no_execute <= ucl_pkg::RST_DF_NX;
			app_secure_size <= ucl_pkg::RST_APP_SEC;
			app_callable_size <= ucl_pkg::RST_APP_NSC;
			dataflash_secure_size <= ucl_pkg::RST_DF_SEC;
			ram_secure_size <= ucl_pkg::RST_RAM_SEC;
			user_row_write_allow <= ucl_pkg::RST_UROW_WR;
		end
		else if (apply)
		begin
			ram_no_execute <= row_flat[ucl_pkg::POS_RAM_NX];
			dataflash_no_execute <= row_flat[ucl_pkg::POS_DF_NX];
			app_secure_size <= as_f;
			app_callable_size <= app_callable_size_f;
			dataflash_secure_size <= ds_f;
			ram_secure_size <= rs_f;
			user_row_write_allow <= row_flat[ucl_pkg::POS_UROW_WR];
		end
	end

	// Region sizes in bytes, kept beside the raw fields for the decoders
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			app_secure_bytes <= {ucl_pkg::RST_APP_SEC, 8'h00};
			app_callable_bytes <= {ucl_pkg::RST_APP_NSC, 5'h00};
			dataflash_secure_bytes <= {ucl_pkg::RST_DF_SEC, 8'h00};
			ram_secure_bytes <= {ucl_pkg::RST_RAM_SEC, 7'h00};
		end
		else if (apply)
		begin
			app_secure_bytes <= 16'(as_f) << ucl_pkg::SH_APP_SEC;
			app_callable_bytes <= 11'(app_callable_size_f) << ucl_pkg::SH_APP_NSC;
			dataflash_secure_bytes <= 12'(ds_f) << ucl_pkg::SH_DF_SEC;
			ram_secure_bytes <= 14'(rs_f) << ucl_pkg::SH_RAM_SEC;
		end
	end

	// Bridge attribute words
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bridge_a_nonsecure_word <= ucl_pkg::RST_BRIDGE;
			bridge_b_nonsecure_word <= ucl_pkg::RST_BRIDGE;
			bridge_c_nonsecure_word <= ucl_pkg::RST_BRIDGE;
		end
		else if (apply)
		begin
			bridge_a_nonsecure_word <= bra_eff;
			bridge_b_nonsecure_word <= brb_eff;
			bridge_c_nonsecure_word <= brc_eff;
		end
	end

	// Bus slave: zero-wait, read data registered in the address phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hready_q <= 1'b1;
			hresp_q <= 1'b0;
			hrdata_q <= 32'h0000_0000;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 32'h0000_0000;
		end
		else
		begin
			hready_q <= 1'b1;
			hresp_q <= 1'b0;
			wr_pend_q <= bus_act & hwrite;
			if (bus_act)
				wr_addr_q <= haddr;
			if (bus_act && !hwrite)
				hrdata_q <= rd_mux;
		end
	end

	// Control register; reload bit is a self-clearing strobe
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			check_en_q <= ucl_pkg::RST_CHECK_EN;
		else if (wr_ctrl)
			check_en_q <= hwdata[ucl_pkg::CTRL_CHECK_EN];
	end

	// Output drive
	assign hreadyout = hready_q;
	assign hresp = hresp_q;
	assign hrdata = hrdata_q;
	assign nvm_rd = rd_q;
	assign nvm_addr = idx_q;
	assign units_release = done_q;
	assign crc_mismatch = crc_err_q;

endmodule

// >>> ucl_pkg.sv
// Constants, field layout and types for the user-row configuration loader.
// Assumes a 256-bit user row read as eight 32-bit words, word 0 first.
package ucl_pkg;

	// Row geometry
	localparam int ROW_WORDS = 8;
	localparam int WORD_W = 32;
	localparam int ADDR_W = 3;
	localparam logic [2:0] CRC_FIRST_WORD = 3'h2;
	localparam logic [2:0] CRC_LAST_WORD = 3'h6;
	localparam logic [2:0] CRC_STORE_WORD = 3'h7;

	// Field bit positions within the row
	localparam int POS_WD_STBY = 25;
	localparam int POS_WD_EN = 26;
	localparam int POS_WD_AON = 27;
	localparam int POS_WD_PER = 28;
	localparam int POS_WD_WIN = 32;
	localparam int POS_WD_EW = 36;
	localparam int POS_WD_WEN = 40;
	localparam int POS_BOD_HYST = 41;
	localparam int POS_RAM_NX = 43;
	localparam int POS_DF_NX = 44;
	localparam int POS_APP_SEC = 64;
	localparam int POS_APP_NSC = 72;
	localparam int POS_DF_SEC = 80;
	localparam int POS_RAM_SEC = 88;
	localparam int POS_UROW_WR = 96;
	localparam int POS_BRIDGE_A = 128;
	localparam int POS_BRIDGE_B = 160;
	localparam int POS_BRIDGE_C = 192;
	localparam int POS_CRC = 224;

	// Factory reset values of the targets
	localparam logic [3:0] RST_WD_PER = 4'hB;
	localparam logic [3:0] RST_WD_WIN = 4'hB;
	localparam logic [3:0] RST_WD_EW = 4'hB;
	localparam logic RST_RAM_NX = 1'b1;
	localparam logic RST_DF_NX = 1'b1;
	localparam logic [7:0] RST_APP_SEC = 8'hFF;
	localparam logic [5:0] RST_APP_NSC = 6'h00;
	localparam logic [3:0] RST_DF_SEC = 4'h8;
	localparam logic [6:0] RST_RAM_SEC = 7'h7F;
	localparam logic RST_UROW_WR = 1'b1;
	localparam logic [31:0] RST_BRIDGE = 32'h0000_0000;

	// Region granule shifts: size = field * 2**shift
	localparam int SH_APP_SEC = 8;
	localparam int SH_APP_NSC = 5;
	localparam int SH_DF_SEC = 8;
	localparam int SH_RAM_SEC = 7;

	// Peripheral bits forced regardless of the fuse value
	localparam logic [31:0] BRA_SEC_MASK = 32'h0000_0001;
	localparam logic [31:0] BRB_SEC_MASK = 32'h0000_0003;
	localparam logic [31:0] BRB_NS_MASK = 32'h0000_0004;

	// Checksum
	localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
	localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;

	// Register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CRC_CALC = 8'h08;
	localparam logic [7:0] REG_CRC_STORED = 8'h0C;
	localparam int CTRL_RELOAD = 0;
	localparam int CTRL_CHECK_EN = 1;
	localparam logic RST_CHECK_EN = 1'b1;
	localparam int ST_DONE = 0;
	localparam int ST_CRC_ERR = 1;
	localparam int ST_BUSY = 2;

	typedef enum logic [2:0]
	{
		S_REQ,
		S_WAIT,
		S_CHECK,
		S_APPLY,
		S_DONE
	} ucl_state_e;

endpackage

// >>> ucl_row_model.sv
// Behavioural user row: answers nvm_rd after lat cycles.
// Assumes the bench sets row and lat while the loader is idle.
`timescale 1ns/10ps

module ucl_row_model
(
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         nvm_rd,
	input  wire logic [2:0]   nvm_addr,
	input  wire logic [255:0] row,
	input  wire logic [2:0]   lat,
	output logic [31:0]       nvm_rdata,
	output logic              nvm_rvalid
);
	logic [2:0] cnt_q;

	// One word per request; data toggles when not valid so stale
	// values can never be mistaken for an answer
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_q <= 3'h0;
			nvm_rvalid <= 1'b0;
			nvm_rdata <= 32'hA5A5_5A5A;
		end
		else
		begin
			nvm_rvalid <= (cnt_q == 3'h1);
			if (nvm_rd)
				cnt_q <= lat;
			else if (cnt_q != 3'h0)
				cnt_q <= cnt_q - 3'h1;
			if (cnt_q == 3'h1)
				nvm_rdata <= row[32*nvm_addr +: 32];
			else
				nvm_rdata <= ~nvm_rdata;
		end
	end
endmodule
